// ---- include/epct_pkg.sv ----
// Constants, types and register map of the three-instance 8-bit compare timer.
// Assumes a single 10 MHz ref_clk domain and a plain synchronous register port.
package epct_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths and instance roles
  localparam int unsigned EPCT_ADDR_W = 4;
  localparam int unsigned EPCT_DATA_W = 8;
  localparam int unsigned EPCT_CNT_W = 8;
  localparam int unsigned EPCT_NUM_TMR = 3;
  localparam int unsigned EPCT_PRESC_W = 7;
  localparam int unsigned EPCT_NUM_SEL = 8;
  localparam int unsigned EPCT_CARRIER_INST = 1;
  localparam int unsigned EPCT_PINLESS_INST = 2;
  localparam int unsigned EPCT_NUM_PINS = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Register map: per-instance block of four, then shared registers
  localparam logic [1:0] EPCT_SUB_MODE = 2'h0;
  localparam logic [1:0] EPCT_SUB_CYCLE = 2'h1;
  localparam logic [1:0] EPCT_SUB_DUTY = 2'h2;
  localparam logic [1:0] EPCT_SUB_COUNT = 2'h3;
  localparam logic [1:0] EPCT_BLK_SHARED = 2'h3;
  localparam logic [3:0] EPCT_OFS_CARRIER = 4'hC;
  localparam logic [3:0] EPCT_OFS_STATUS = 4'hD;
  localparam logic [3:0] EPCT_OFS_MASK = 4'hE;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and counter step
  localparam logic [7:0] EPCT_RST_BYTE = 8'h00;
  localparam logic [2:0] EPCT_RST_IRQ = 3'h0;
  localparam logic [7:0] EPCT_CNT_STEP = 8'h01;

  ////////////////////////////////////////////////////////////////////////////
  // Modes and comparison phase
  typedef enum logic [1:0] {
    EPCT_MODE_INTERVAL = 2'h0,
    EPCT_MODE_PWM = 2'h1,
    EPCT_MODE_CARRIER = 2'h3
  } epct_tmode_t;

  typedef enum logic {
    EPCT_PH_CYCLE = 1'b0,
    EPCT_PH_DUTY = 1'b1
  } epct_phase_t;

  // Timer mode register layout
  typedef struct packed {
    logic enable;
    logic rsv6;
    logic [1:0] mode;
    logic rsv3;
    logic [2:0] clk_sel;
  } epct_mode_reg_t;

  // Carrier control register layout; env_level is read-only
  typedef struct packed {
    logic env_level;
    logic [3:0] rsv;
    logic gate_en;
    logic carrier_mode;
    logic carrier_data;
  } epct_carrier_reg_t;

  // Configuration handed to one timer instance
  typedef struct packed {
    logic enable;
    epct_tmode_t mode;
    logic [7:0] cycle;
    logic [7:0] duty;
  } epct_tmr_cfg_t;

endpackage

// ---- core/epct_timer_core.sv ----
// One 8-bit compare timer: up-counter, cycle and duty comparison, output flop.
// Assumes tick is a one-cycle count enable from the shared prescaler.
`timescale 1ns/10ps
`default_nettype none

module epct_timer_core #(
  parameter bit CARRIER_OK = 1'b0
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire epct_pkg::epct_tmr_cfg_t cfg,
  input wire logic tick,
  output logic [7:0] count,
  output logic match_pulse,
  output logic tmr_out
);

  epct_pkg::epct_tmode_t mode_eff;
  epct_pkg::epct_phase_t phase;
  logic [7:0] cmp_val;
  logic hit;

  ////////////////////////////////////////////////////////////////////////////
  // Undefined or unsupported modes fall back to interval timing
  always_comb begin
    case (cfg.mode)
      epct_pkg::EPCT_MODE_PWM: mode_eff = epct_pkg::EPCT_MODE_PWM;
      epct_pkg::EPCT_MODE_CARRIER: begin
        mode_eff = CARRIER_OK ? epct_pkg::EPCT_MODE_CARRIER : epct_pkg::EPCT_MODE_INTERVAL;
      end
      default: mode_eff = epct_pkg::EPCT_MODE_INTERVAL;
    endcase
  end

  // Duty value is read live, so a rewrite takes effect at the next comparison, even within a running duty phase
  assign cmp_val = (phase == epct_pkg::EPCT_PH_DUTY) ? cfg.duty : cfg.cycle;
  assign hit = tick && (count == cmp_val);

  ////////////////////////////////////////////////////////////////////////////
  // Counter
  always_ff @(posedge ref_clk) begin
    if (!nrst || !cfg.enable) begin
      count <= '0;
    end else if (hit && (phase == epct_pkg::EPCT_PH_CYCLE ||
                         mode_eff == epct_pkg::EPCT_MODE_CARRIER)) begin
      count <= '0;
    end else if (tick) begin
      count <= count + epct_pkg::EPCT_CNT_STEP;
    end
  end

  // Comparison phase: cycle first, then duty outside interval mode, then back
  always_ff @(posedge ref_clk) begin
    if (!nrst || !cfg.enable) begin
      phase <= epct_pkg::EPCT_PH_CYCLE;
    end else if (hit) begin
      case (phase)
        epct_pkg::EPCT_PH_CYCLE: begin
          if (mode_eff != epct_pkg::EPCT_MODE_INTERVAL) begin
            phase <= epct_pkg::EPCT_PH_DUTY;
          end
        end
        default: phase <= epct_pkg::EPCT_PH_CYCLE;
      endcase
    end
  end

  // Output level and match pulse
  always_ff @(posedge ref_clk) begin
    if (!nrst || !cfg.enable) begin
      tmr_out <= 1'b0;
      match_pulse <= 1'b0;
    end else begin
      match_pulse <= hit && (phase == epct_pkg::EPCT_PH_CYCLE);
      if (hit && phase == epct_pkg::EPCT_PH_CYCLE) begin
        tmr_out <= (mode_eff == epct_pkg::EPCT_MODE_INTERVAL) ? !tmr_out : 1'b1;
      end else if (hit) begin
        tmr_out <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  AST_CYCLE_MATCH: assert property (@(posedge ref_clk) disable iff (!nrst)
    cfg.enable && hit && phase == epct_pkg::EPCT_PH_CYCLE &&
    mode_eff != epct_pkg::EPCT_MODE_INTERVAL && $stable(cfg.enable) ##0 $past(cfg.enable)
    |=> count == '0 && tmr_out && match_pulse && phase == epct_pkg::EPCT_PH_DUTY)
    else $error("cycle match did not clear, pulse and drive active");
  AST_DUTY_INACTIVE: assert property (@(posedge ref_clk) disable iff (!nrst)
    cfg.enable && hit && phase == epct_pkg::EPCT_PH_DUTY |=> cfg.enable -> !tmr_out)
    else $error("duty match did not drive inactive level");
  AST_BACK_TO_CYCLE: assert property (@(posedge ref_clk) disable iff (!nrst)
    cfg.enable && hit && phase == epct_pkg::EPCT_PH_DUTY |=> phase == epct_pkg::EPCT_PH_CYCLE)
    else $error("duty match did not return to cycle comparison");
  AST_STOP_CLEARS: assert property (@(posedge ref_clk) disable iff (!nrst)
    !cfg.enable |=> count == '0 && !tmr_out && !match_pulse)
    else $error("disabled timer not cleared");
  AST_HOLD_NO_TICK: assert property (@(posedge ref_clk) disable iff (!nrst)
    cfg.enable && !tick ##1 cfg.enable |-> $stable(count))
    else $error("counter moved without a tick");

endmodule // epct_timer_core

`default_nettype wire

// ---- core/epct_top.sv ----
// Three 8-bit compare timers with register port, carrier gating and interrupts.
// Assumes all inputs are synchronous to ref_clk; envelope and event inputs are levels.
//
// The address-and-strobe port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

module epct_top (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic envelope_timer_interrupt,
  input wire logic event_count_input,
  output logic [1:0] timer_output_pin,
  output logic event_count_enable,
  output logic event_count_gated,
  output logic [2:0] match_interrupt,
  output logic irq
);

  epct_pkg::epct_mode_reg_t mode_reg [epct_pkg::EPCT_NUM_TMR];
  logic [7:0] cycle_compare_reg [epct_pkg::EPCT_NUM_TMR];
  logic [7:0] duty_compare_reg [epct_pkg::EPCT_NUM_TMR];
  logic [7:0] count [epct_pkg::EPCT_NUM_TMR];
  epct_pkg::epct_tmr_cfg_t cfg [epct_pkg::EPCT_NUM_TMR];
  logic [epct_pkg::EPCT_NUM_TMR-1:0] tick;
  logic [epct_pkg::EPCT_NUM_TMR-1:0] tmr_out;
  logic [epct_pkg::EPCT_NUM_TMR-1:0] match_pulse;
  epct_pkg::epct_carrier_reg_t carrier_control_reg;
  logic [2:0] carrier_wr_bits;
  logic [2:0] int_status;
  logic [2:0] int_mask;
  logic [2:0] clr_bits;
  logic [epct_pkg::EPCT_PRESC_W-1:0] presc;
  logic [epct_pkg::EPCT_NUM_SEL-1:0] tick_vec;
  logic env_prev;
  logic env_rise;
  logic carrier_gate;
  logic next_carrier_gate;
  logic carrier_sel;
  logic carrier_pin;
  logic next_carrier_pin;
  logic [1:0] blk;
  logic [1:0] sub;
  logic [7:0] next_rdata;

  assign blk = reg_addr[3:2];
  assign sub = reg_addr[1:0];

  ////////////////////////////////////////////////////////////////////////////
  // Shared prescaler; free running so every select sees a steady rate
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      presc <= '0;
    end else begin
      presc <= presc + {{(epct_pkg::EPCT_PRESC_W-1){1'b0}}, 1'b1};
    end
  end

  // Select k ticks once every 2^k cycles
  assign tick_vec[0] = 1'b1;
  for (genvar k = 1; k < epct_pkg::EPCT_NUM_SEL; k++) begin : g_tick
    assign tick_vec[k] = &presc[k-1:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-instance registers and timer cores
  for (genvar i = 0; i < epct_pkg::EPCT_NUM_TMR; i++) begin : g_tmr
    localparam logic [1:0] BLK = 2'(i);

    // Mode, cycle and duty registers written through the register port
    always_ff @(posedge ref_clk) begin
      if (!nrst) begin
        mode_reg[i] <= epct_pkg::EPCT_RST_BYTE;
        cycle_compare_reg[i] <= epct_pkg::EPCT_RST_BYTE;
        duty_compare_reg[i] <= epct_pkg::EPCT_RST_BYTE;
      end else if (reg_wr && blk == BLK) begin
        if (sub == epct_pkg::EPCT_SUB_MODE) begin
          mode_reg[i] <= reg_wdata;
        end else if (sub == epct_pkg::EPCT_SUB_CYCLE) begin
          cycle_compare_reg[i] <= reg_wdata;
        end else if (sub == epct_pkg::EPCT_SUB_DUTY) begin
          duty_compare_reg[i] <= reg_wdata;
        end
      end
    end

    // Configuration bundle for the core
    assign cfg[i].enable = mode_reg[i].enable;
    assign cfg[i].mode = epct_pkg::epct_tmode_t'(mode_reg[i].mode);
    assign cfg[i].cycle = cycle_compare_reg[i];
    assign cfg[i].duty = duty_compare_reg[i];
    assign tick[i] = tick_vec[mode_reg[i].clk_sel];

    epct_timer_core #(
      .CARRIER_OK(i == epct_pkg::EPCT_CARRIER_INST)
    ) u_core (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .cfg(cfg[i]),
      .tick(tick[i]),
      .count(count[i]),
      .match_pulse(match_pulse[i]),
      .tmr_out(tmr_out[i])
    );
  end

  assign match_interrupt = match_pulse;

  ////////////////////////////////////////////////////////////////////////////
  // Carrier control register; bit 7 reads the envelope input level
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      carrier_wr_bits <= '0;
    end else if (reg_wr && reg_addr == epct_pkg::EPCT_OFS_CARRIER) begin
      carrier_wr_bits <= reg_wdata[2:0];
    end
  end
  // One driver for the whole register; flops and live level never share a variable
  assign carrier_control_reg = {envelope_timer_interrupt, 4'h0, carrier_wr_bits};

  ////////////////////////////////////////////////////////////////////////////
  // Envelope edge detect; data is only taken on a rising edge
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      env_prev <= 1'b0;
    end else begin
      env_prev <= envelope_timer_interrupt;
    end
  end
  assign env_rise = envelope_timer_interrupt && !env_prev;

  // Gate opens at an envelope edge, closes at once when data is cleared
  always_comb begin
    next_carrier_gate = carrier_gate;
    if (!carrier_control_reg.carrier_data) begin
      next_carrier_gate = 1'b0;
    end else if (env_rise) begin
      next_carrier_gate = 1'b1;
    end
  end

  assign carrier_sel = (mode_reg[epct_pkg::EPCT_CARRIER_INST].mode == epct_pkg::EPCT_MODE_CARRIER);

  // Pin 1: carrier, steady high or plain timer output
  always_comb begin
    next_carrier_pin = tmr_out[epct_pkg::EPCT_CARRIER_INST];
    if (carrier_sel) begin
      if (!next_carrier_gate) begin
        next_carrier_pin = 1'b0;
      end else if (carrier_control_reg.carrier_mode) begin
        next_carrier_pin = tmr_out[epct_pkg::EPCT_CARRIER_INST];
      end else begin
        next_carrier_pin = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      carrier_gate <= 1'b0;
      carrier_pin <= 1'b0;
    end else begin
      carrier_gate <= next_carrier_gate;
      carrier_pin <= next_carrier_pin;
    end
  end

  // Only instances 0 and 1 reach pins; instance 2 stays internal
  assign timer_output_pin[0] = tmr_out[0];
  assign timer_output_pin[1] = carrier_pin;

  ////////////////////////////////////////////////////////////////////////////
  // Pinless instance gates the event count input
  assign event_count_enable = tmr_out[epct_pkg::EPCT_PINLESS_INST];
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      event_count_gated <= 1'b0;
    end else begin
      event_count_gated <= event_count_input &&
        (!carrier_control_reg.gate_en || tmr_out[epct_pkg::EPCT_PINLESS_INST]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status; a match in the clearing cycle survives the clear
  assign clr_bits = (reg_wr && reg_addr == epct_pkg::EPCT_OFS_STATUS) ? reg_wdata[2:0] : '0;
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      int_status <= epct_pkg::EPCT_RST_IRQ;
    end else begin
      int_status <= (int_status & ~clr_bits) | match_pulse;
    end
  end

  // Mask register
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      int_mask <= epct_pkg::EPCT_RST_IRQ;
    end else if (reg_wr && reg_addr == epct_pkg::EPCT_OFS_MASK) begin
      int_mask <= reg_wdata[2:0];
    end
  end

  assign irq = |(int_status & int_mask);

  ////////////////////////////////////////////////////////////////////////////
  // Read decode; unmapped addresses read as zero
  always_comb begin
    next_rdata = '0;
    if (blk != epct_pkg::EPCT_BLK_SHARED) begin
      if (sub == epct_pkg::EPCT_SUB_MODE) begin
        next_rdata = mode_reg[blk];
      end else if (sub == epct_pkg::EPCT_SUB_CYCLE) begin
        next_rdata = cycle_compare_reg[blk];
      end else if (sub == epct_pkg::EPCT_SUB_DUTY) begin
        next_rdata = duty_compare_reg[blk];
      end else begin
        next_rdata = count[blk];
      end
    end else if (reg_addr == epct_pkg::EPCT_OFS_CARRIER) begin
      next_rdata = carrier_control_reg;
    end else if (reg_addr == epct_pkg::EPCT_OFS_STATUS) begin
      next_rdata = {5'h00, int_status};
    end else if (reg_addr == epct_pkg::EPCT_OFS_MASK) begin
      next_rdata = {5'h00, int_mask};
    end
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= reg_rd ? next_rdata : '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  AST_MATCH_STICKY: assert property (@(posedge ref_clk) disable iff (!nrst)
    match_pulse[0] |=> int_status[0])
    else $error("match did not set its status bit");
  AST_ENABLE_START: assert property (@(posedge ref_clk) disable iff (!nrst)
    reg_wr && reg_addr == {2'h0, epct_pkg::EPCT_SUB_MODE} && !reg_wdata[7] |=>
    ##1 count[0] == '0)
    else $error("counter ran without enable");
  AST_DATA_LOW: assert property (@(posedge ref_clk) disable iff (!nrst)
    carrier_sel && !carrier_control_reg.carrier_data |=> !timer_output_pin[1])
    else $error("carrier pin not low with data clear");
  AST_STEADY_HIGH: assert property (@(posedge ref_clk) disable iff (!nrst)
    carrier_sel && env_rise && carrier_control_reg.carrier_data &&
    !carrier_control_reg.carrier_mode |=> timer_output_pin[1])
    else $error("steady high not driven at envelope edge");
  AST_CARRIER_FOLLOW: assert property (@(posedge ref_clk) disable iff (!nrst)
    carrier_sel && next_carrier_gate && carrier_control_reg.carrier_mode |=>
    timer_output_pin[1] == $past(tmr_out[1]))
    else $error("carrier pin does not follow timer 1");
  AST_EVENT_BLOCK: assert property (@(posedge ref_clk) disable iff (!nrst)
    carrier_control_reg.gate_en && !event_count_enable |=> !event_count_gated)
    else $error("event input passed while pinless timer output low");
  AST_READ_ONCE: assert property (@(posedge ref_clk) disable iff (!nrst)
    !reg_rd |=> reg_rdata == '0)
    else $error("read data outside its cycle");

endmodule // epct_top

`default_nettype wire

// ---- tb/epct_load_model.sv ----
// Load model for the two timer pins: measures pulse widths like a scope would.
// Assumes pins are flop outputs of the ref_clk domain; it drives nothing back.
`timescale 1ns/10ps
`default_nettype none

module epct_load_model (
  input wire logic ref_clk,
  input wire logic [1:0] pin,
  output logic [1:0][7:0] high_len,
  output logic [1:0][7:0] low_len,
  output logic [1:0][15:0] rises
);
  logic [1:0] last;
  logic [1:0][7:0] run;

  // Start from a quiet, low load
  initial begin
    last = 2'h0;
    run = '0;
    high_len = '0;
    low_len = '0;
    rises = '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Run length per pin; a width is stored only once it has ended
  always @(posedge ref_clk) begin
    for (int i = 0; i < 2; i++) begin
      if (pin[i] === last[i]) begin
        run[i] <= run[i] + 8'h01;
      end else begin
        if (last[i]) high_len[i] <= run[i];
        else low_len[i] <= run[i];
        if (pin[i] === 1'b1) rises[i] <= rises[i] + 16'h0001;
        run[i] <= 8'h01;
        last[i] <= pin[i];
      end
    end
  end
endmodule // epct_load_model

`default_nettype wire

// ---- tb/tb.sv ----
// Self-checking bench for the three-instance compare timer.
// Assumes the register map and mode encodings of the design package.
`timescale 1ns/10ps
`default_nettype none

module tb;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic env = 1'b0;
  logic evt = 1'b0;
  wire logic [7:0] reg_rdata;
  wire logic [1:0] pins;
  wire logic ev_en;
  wire logic ev_gated;
  wire logic [2:0] mirq;
  wire logic irq;
  wire logic [1:0][7:0] hl;
  wire logic [1:0][7:0] ll;
  wire logic [1:0][15:0] ri;
  int fail_count = 0;
  int checks_done = 0;
  int cyc = 0;
  int mcnt = 0;
  int m0;
  int h;
  int g;
  logic [15:0] r0;
  logic [7:0] rv;

  epct_top epct_top_i (.ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .envelope_timer_interrupt(env), .event_count_input(evt), .timer_output_pin(pins),
    .event_count_enable(ev_en), .event_count_gated(ev_gated), .match_interrupt(mirq),
    .irq(irq));

  epct_load_model epct_load_model_i (.ref_clk(ref_clk), .pin(pins), .high_len(hl),
    .low_len(ll), .rises(ri));

  ////////////////////////////////////////////////////////////////////////////
  // Clock, hang guard and match pulse counter
  initial begin
    forever #50 ref_clk = ~ref_clk;
  end

  // Ceiling well above the roughly 600 cycles the tests need
  always @(posedge ref_clk) begin
    cyc++;
    if (mirq[0] === 1'b1) mcnt++;
    if (cyc == 5000) begin
      fail_count++;
      test_done();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register port tasks; strobes drop a full edge before the next call
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe edge
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic rchk(input logic [3:0] a, input logic [7:0] exp, input string nm);
    logic [7:0] d;
    rd(a, d);
    chk(nm, {8'h00, d}, {8'h00, exp});
  endtask

  task automatic ticks(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Test sequence
  initial begin
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    // Every register and the unmapped slot read zero
    for (int a = 0; a < 16; a++) begin
      rd(a[3:0], rv);
      chk("reset reg", {8'h00, rv}, 16'h0000);
    end
    $display("test reset done");
    // Compare values loaded but counting not enabled
    wr(4'h1, 8'h04);
    wr(4'h2, 8'h01);
    wr(4'h0, 8'h10);
    ticks(20);
    rchk(4'h3, 8'h00, "idle count");
    chk("idle pin", {15'h0, pins[0]}, 16'h0000);
    // PWM, period 5, high 2
    wr(4'h0, 8'h90);
    ticks(60);
    chk("pwm high", {8'h00, hl[0]}, 16'h0002);
    chk("pwm low", {8'h00, ll[0]}, 16'h0003);
    m0 = mcnt;
    r0 = ri[0];
    ticks(50);
    chk("match pulses", 16'(mcnt - m0), 16'd10);
    chk("pwm rises", ri[0] - r0, 16'd10);
    // Duty widened while running
    wr(4'h2, 8'h02);
    ticks(30);
    chk("new duty high", {8'h00, hl[0]}, 16'h0003);
    chk("new duty low", {8'h00, ll[0]}, 16'h0002);
    wr(4'h0, 8'h00);
    ticks(2);
    rchk(4'h3, 8'h00, "stop count");
    chk("stop pin", {15'h0, pins[0]}, 16'h0000);
    // Tick every second cycle doubles every width
    wr(4'h0, 8'h91);
    ticks(80);
    chk("slow high", {8'h00, hl[0]}, 16'h0006);
    chk("slow low", {8'h00, ll[0]}, 16'h0004);
    wr(4'h0, 8'h00);
    $display("test pwm done");
    // Interval toggling, sticky status, mask and clear
    // Carrier code on instance 0 must fall back to interval toggling
    wr(4'h1, 8'h03);
    wr(4'h0, 8'hB0);
    ticks(40);
    chk("square high", {8'h00, hl[0]}, 16'h0004);
    chk("irq masked", {15'h0, irq}, 16'h0000);
    rchk(4'hD, 8'h01, "status set");
    wr(4'hE, 8'h01);
    ticks(1);
    chk("irq unmasked", {15'h0, irq}, 16'h0001);
    wr(4'h0, 8'h00);
    ticks(2);
    wr(4'hD, 8'h01);
    ticks(1);
    chk("irq cleared", {15'h0, irq}, 16'h0000);
    rchk(4'hD, 8'h00, "status clear");
    $display("test irq done");
    // Carrier: low 4, high 2, gated by the envelope
    wr(4'h5, 8'h03);
    wr(4'h6, 8'h01);
    wr(4'h4, 8'hB0);
    wr(4'hC, 8'h03);
    @(posedge ref_clk);
    env <= 1'b1;
    ticks(60);
    chk("carrier high", {8'h00, hl[1]}, 16'h0002);
    chk("carrier low", {8'h00, ll[1]}, 16'h0004);
    rchk(4'hC, 8'h83, "carrier ctrl");
    wr(4'hC, 8'h02);
    ticks(2);
    r0 = ri[1];
    ticks(20);
    chk("data off pin", {15'h0, pins[1]}, 16'h0000);
    chk("data off rises", ri[1] - r0, 16'h0000);
    @(posedge ref_clk);
    env <= 1'b0;
    wr(4'hC, 8'h01);
    ticks(4);
    chk("level before edge", {15'h0, pins[1]}, 16'h0000);
    @(posedge ref_clk);
    env <= 1'b1;
    ticks(2);
    r0 = ri[1];
    ticks(20);
    chk("steady level", {15'h0, pins[1]}, 16'h0001);
    chk("steady no pulses", ri[1] - r0, 16'h0000);
    wr(4'hC, 8'h00);
    wr(4'h4, 8'h00);
    $display("test carrier done");
    // Pinless instance gating the event input
    @(posedge ref_clk);
    evt <= 1'b1;
    ticks(3);
    chk("ungated event", {15'h0, ev_gated}, 16'h0001);
    wr(4'hC, 8'h04);
    ticks(3);
    chk("gate shut", {15'h0, ev_gated}, 16'h0000);
    wr(4'h9, 8'h04);
    wr(4'hA, 8'h01);
    wr(4'h8, 8'h90);
    ticks(40);
    h = 0;
    g = 0;
    repeat (50) begin
      @(posedge ref_clk);
      #1;
      if (ev_en === 1'b1) h++;
      if (ev_gated === 1'b1) g++;
    end
    chk("gate high cycles", 16'(h), 16'd20);
    chk("gated event cycles", 16'(g), 16'd20);
    chk("no pin driven", {14'h0, pins}, 16'h0000);
    rchk(4'hD, 8'h06, "status bits");
    $display("test pinless done");
    test_done();
  end
endmodule // tb

`default_nettype wire
